// File: hdl/srdc_top.sv
// Receive-only serial interface with data-set handshaking and bit timer
// What this block does
// - Receive-message output enabled only while selector is in normal position
// - DTR on only with printer ready, paper sufficient or call up, and on-hook timer unexpired
// - Low paper drops DTR only before a call is answered
// - DSR on with paper sufficient asserts receive-message output
// - On-hook timer runs while receive-message asserted and DCD off
// - DCD must come within 15 s; DCD resets timer; expiry drops DTR
// - Data passes only with DCD on and RI off; else idle mark
// - STD follows auto_on_ready input
// - Bit timer divides free-running oscillator by 64; flop shapes pulse
// - Timer counter and pulse flop held cleared while run is false
// - Pulses about 11 us wide every 476 us at 1050 baud
// - Idle mark line makes no control signals or shift clocks
// - Start bit space sets timer run and starts the bit timer
// - First pulse resets stages except last; reset ends when all read set and the settling time has passed
// - Pulses run at twice bit rate; toggle yields one shift clock per bit
// - Until complete: timer runs, available timer off, register reset suppressed
// - Complete when start bit at end and stop mark in first stage
// - Late variant: character available at once for about 80 us
// - Early variant: character available after 80 us for about 20 us
// - One available pulse per character; next start bit re-arms latch
// - DCD off runs timer; expiry drops DTR and forces data to mark
// - DSR off drops receive-message and resets timer for next call
`timescale 1ns/10ps
module srdc_top
	import srdc_pkg::*;
#(
	parameter int      FRAME_LEN   = FRAME_W,
	parameter int      PRESCALE    = PRESCALE_CYC,
	parameter longint  ON_HOOK_LEN = ON_HOOK_CYC,
	parameter int      CA_LATE     = CA_LATE_CYC,
	parameter int      CA_DLY      = CA_EARLY_DLY_CYC,
	parameter int      CA_LEN      = CA_EARLY_LEN_CYC,
	parameter bit      LATE_DESIGN = 1'b1
) (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	// Printer side
	input  wire logic                 normal_test_selector,
	input  wire logic                 printer_ready,
	input  wire logic                 paper_sufficient,
	input  wire logic                 auto_on_ready,
	output logic                      receive_message_out,
	output logic                      character_available,
	output logic                      rd_out,
	output logic [FRAME_LEN-1:0]      char_word,
	// Data set side
	input  wire logic                 dsr,
	input  wire logic                 dcd,
	input  wire logic                 ri,
	input  wire logic                 rd_in,
	output logic                      dtr,
	output logic                      std_out,
	// Character stream
	output logic [FIFO_W-1:0]         fifo_data,
	output logic                      fifo_valid,
	input  wire logic                 fifo_ready,
	// Status
	output logic                      on_hook_expired,
	output logic                      overrun
);
	// ----------------------------------------------------------------
	// Modem control
	// ----------------------------------------------------------------
	logic [CNT_W+7:0]       hook_cnt_ff;
	logic                   hook_exp_ff;
	logic                   call_up_ff;
	logic                   rm_ff;
	logic                   dtr_ff;
	logic                   std_ff;
	logic                   rd_ff;
	logic                   hook_run;
	logic                   data_gate;
	logic                   rd_line;

	assign hook_run  = rm_ff && !dcd;
	assign data_gate = dcd && !ri && !hook_exp_ff;
	assign rd_line   = data_gate ? rd_in : 1'b1;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hook_cnt_ff <= '0;
			hook_exp_ff <= 1'b0;
		end else if (!dsr || dcd) begin
			hook_cnt_ff <= '0;
			hook_exp_ff <= 1'b0;
		end else if (hook_run && !hook_exp_ff) begin
			hook_cnt_ff <= hook_cnt_ff + 1'b1;
			if (hook_cnt_ff == (CNT_W+8)'(ON_HOOK_LEN - 1)) begin
				hook_exp_ff <= 1'b1;
			end
		end
	end

	// Call counts as established once DSR is on
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			call_up_ff <= 1'b0;
		end else begin
			call_up_ff <= dsr;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rm_ff   <= 1'b0;
			dtr_ff  <= 1'b0;
			std_ff  <= 1'b0;
			rd_ff   <= 1'b1;
		end else begin
			rm_ff  <= normal_test_selector && dsr && (paper_sufficient || call_up_ff);
			dtr_ff <= printer_ready && (paper_sufficient || call_up_ff) && !hook_exp_ff;
			std_ff <= auto_on_ready;
			rd_ff  <= rd_line;
		end
	end

	assign receive_message_out = rm_ff;
	assign dtr                 = dtr_ff;
	assign std_out             = std_ff;
	assign rd_out              = rd_ff;
	assign on_hook_expired     = hook_exp_ff;

	// ----------------------------------------------------------------
	// Bit timer
	// ----------------------------------------------------------------
	logic              run_ff;
	logic [15:0]       pre_ff;
	logic [5:0]        div_ff;
	logic [15:0]       pw_ff;
	logic              tick_ff;
	logic              osc_edge;

	// Pulse width follows the oscillator, but must outlast the register reset
	localparam int TICK_W_OSC = (TICK_WIDTH_CYC * PRESCALE) / PRESCALE_CYC;
	localparam int TICK_W     = (TICK_W_OSC > REG_RESET_CYC + 4) ? TICK_W_OSC : REG_RESET_CYC + 4;

	// Prescaler stands in for the crystal; free running like the oscillator
	assign osc_edge = (pre_ff == 16'(PRESCALE - 1));

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_ff <= '0;
		end else begin
			pre_ff <= osc_edge ? '0 : pre_ff + 1'b1;
		end
	end

	// Counter and shaping flop held clear while not running
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff  <= '0;
			tick_ff <= 1'b0;
			pw_ff   <= '0;
		end else if (!run_ff) begin
			div_ff  <= '0;
			tick_ff <= 1'b0;
			pw_ff   <= '0;
		end else begin
			if (osc_edge) begin
				div_ff <= div_ff + 1'b1;
			end
			if (osc_edge && div_ff == 6'(OSC_DIV - 1)) begin
				tick_ff <= 1'b1;
				pw_ff   <= 16'(TICK_W - 1);
			end else if (pw_ff != '0) begin
				pw_ff <= pw_ff - 1'b1;
			end else begin
				tick_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive distributor
	// ----------------------------------------------------------------
	srdc_state_t          st_ff;
	logic [FRAME_LEN-1:0] sr_ff;
	logic                 tick_d_ff;
	logic                 half_ff;
	logic [3:0]           rr_cnt_ff;
	logic                 done_ff;
	logic                 tick_fall;
	logic                 tick_rise;
	logic                 shift_clock_pulse;
	logic                 start_bit_at_end;
	logic                 stop_bit_seen;
	logic                 register_reset;
	logic                 all_set;

	assign tick_fall         = tick_d_ff && !tick_ff;
	assign tick_rise         = tick_ff && !tick_d_ff;
	assign shift_clock_pulse = tick_fall && !half_ff && (st_ff == SRDC_SHIFT);
	assign start_bit_at_end  = !sr_ff[FRAME_LEN-1];
	assign stop_bit_seen     = sr_ff[0];
	assign register_reset    = (st_ff == SRDC_CLEAR);
	assign all_set           = &sr_ff[FRAME_LEN-2:0];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_d_ff <= 1'b0;
		end else begin
			tick_d_ff <= tick_ff;
		end
	end

	// Distributor sequence; idle mark keeps everything quiet
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff     <= SRDC_IDLE;
			run_ff    <= 1'b0;
			half_ff   <= 1'b0;
			rr_cnt_ff <= '0;
			done_ff   <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			case (st_ff)
				SRDC_IDLE: begin
					half_ff <= 1'b0;
					if (!rd_ff) begin
						run_ff <= 1'b1;
						st_ff  <= SRDC_SHIFT;
					end
				end
				SRDC_SHIFT: begin
					// Rise of the first pulse clears the register; its fall shifts the start bit
					if (tick_rise && rr_cnt_ff == '0) begin
						st_ff <= SRDC_CLEAR;
					end else if (tick_fall) begin
						half_ff <= !half_ff;
					end
					if (start_bit_at_end && stop_bit_seen) begin
						run_ff  <= 1'b0;
						done_ff <= 1'b1;
						st_ff   <= SRDC_DONE;
					end
				end
				SRDC_CLEAR: begin
					rr_cnt_ff <= rr_cnt_ff + 1'b1;
					// Reset lasts until decoded, at least the settling time
					if (all_set && rr_cnt_ff >= 4'(REG_RESET_CYC - 1)) begin
						st_ff <= SRDC_SHIFT;
					end
				end
				default: begin
					// Wait for line to return to mark before re-arming
					rr_cnt_ff <= '0;
					if (rd_ff) begin
						st_ff <= SRDC_IDLE;
					end
				end
			endcase
		end
	end

	// Shift register, stop end at bit 0, start bit travels to the top
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_ff <= '1;
		end else if (register_reset) begin
			sr_ff[FRAME_LEN-2:0] <= '1;
		end else if (shift_clock_pulse) begin
			sr_ff <= {sr_ff[FRAME_LEN-2:0], rd_ff};
		end else if (st_ff == SRDC_IDLE && rd_ff) begin
			sr_ff[FRAME_LEN-1] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Character available
	// ----------------------------------------------------------------
	logic [15:0]          ca_cnt_ff;
	logic                 ca_armed_ff;
	logic                 ca_ff;
	logic                 ca_wait_ff;
	logic [FRAME_LEN-1:0] word_ff;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ca_armed_ff <= 1'b1;
			ca_ff       <= 1'b0;
			ca_wait_ff  <= 1'b0;
			ca_cnt_ff   <= '0;
			word_ff     <= '1;
		end else begin
			if (st_ff == SRDC_IDLE && !rd_ff) begin
				ca_armed_ff <= 1'b1;
			end
			if (done_ff && ca_armed_ff) begin
				ca_armed_ff <= 1'b0;
				word_ff     <= sr_ff;
				if (LATE_DESIGN) begin
					ca_ff     <= 1'b1;
					ca_cnt_ff <= 16'(CA_LATE - 1);
				end else begin
					ca_wait_ff <= 1'b1;
					ca_cnt_ff  <= 16'(CA_DLY - 1);
				end
			end else if (ca_cnt_ff != '0) begin
				ca_cnt_ff <= ca_cnt_ff - 1'b1;
			end else if (ca_wait_ff) begin
				ca_wait_ff <= 1'b0;
				ca_ff      <= 1'b1;
				ca_cnt_ff  <= 16'(CA_LEN - 1);
			end else begin
				ca_ff <= 1'b0;
			end
		end
	end

	assign character_available = ca_ff;
	assign char_word           = word_ff;

	// ----------------------------------------------------------------
	// FIFO of received characters
	// ----------------------------------------------------------------
	srdc_fifo_if #(.W(FIFO_W)) fif ();
	logic push_ff;
	logic ovr_ff;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			push_ff <= 1'b0;
			ovr_ff  <= 1'b0;
		end else begin
			push_ff <= done_ff && ca_armed_ff;
			// A full FIFO drops the character; sticky flag tells the user
			if (push_ff && !fif.ready) begin
				ovr_ff <= 1'b1;
			end
		end
	end

	assign fif.valid = push_ff;
	assign fif.data  = word_ff[FRAME_LEN-2:FRAME_LEN-1-FIFO_W];
	assign overrun   = ovr_ff;

	srdc_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.wr       (fif.snk),
		.rd_data  (fifo_data),
		.rd_valid (fifo_valid),
		.rd_ready (fifo_ready)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	rm_norm_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!normal_test_selector |=> !receive_message_out) else $error("rm without normal");
	dtr_ready_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!printer_ready |=> !dtr) else $error("dtr without ready");
	dtr_expiry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hook_exp_ff |=> !dtr) else $error("dtr after expiry");
	dcd_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		dcd |=> !hook_exp_ff && hook_cnt_ff == '0) else $error("timer not reset");
	std_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		std_out == $past(auto_on_ready)) else $error("std mismatch");
	rd_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ri |=> rd_out) else $error("data passed during ring");
	timer_held_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!run_ff |=> div_ff == '0 && !tick_ff) else $error("timer not held");
	idle_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		st_ff == SRDC_IDLE |-> !shift_clock_pulse && !register_reset) else $error("idle activity");
	start_run_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		st_ff == SRDC_IDLE && !rd_ff |=> run_ff) else $error("start not seen");
	done_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		done_ff |-> !run_ff) else $error("timer runs after completion");

	char_done_c: cover property (@(posedge ref_clk) done_ff);
	ca_pulse_c:  cover property (@(posedge ref_clk) $rose(character_available));
	expiry_c:    cover property (@(posedge ref_clk) $rose(hook_exp_ff));
endmodule

// File: common/srdc_pkg.sv
// Package of constants for the serial receive data-set control block
package srdc_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 50_000_000;
	localparam int CLK_PERIOD_NS   = 20;
	// Half-bit tick for 1050 baud: pulses at twice the bit rate
	localparam int TICK_PERIOD_US  = 476;
	localparam int TICK_WIDTH_US   = 11;
	localparam int OSC_DIV         = 64;
	// Oscillator prescale so that OSC_DIV oscillator periods make one tick
	localparam int PRESCALE_CYC    = (TICK_PERIOD_US * 1000) / (CLK_PERIOD_NS * OSC_DIV);
	localparam int TICK_WIDTH_CYC  = (TICK_WIDTH_US * 1000) / CLK_PERIOD_NS;
	localparam int REG_RESET_NS    = 300;
	localparam int REG_RESET_CYC   = (REG_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CA_LATE_US      = 80;
	localparam int CA_EARLY_DLY_US = 80;
	localparam int CA_EARLY_LEN_US = 20;
	localparam int CA_LATE_CYC     = (CA_LATE_US * 1000) / CLK_PERIOD_NS;
	localparam int CA_EARLY_DLY_CYC = (CA_EARLY_DLY_US * 1000) / CLK_PERIOD_NS;
	localparam int CA_EARLY_LEN_CYC = (CA_EARLY_LEN_US * 1000) / CLK_PERIOD_NS;
	localparam int ON_HOOK_S       = 15;
	localparam longint ON_HOOK_CYC = longint'(ON_HOOK_S) * longint'(CLK_HZ);
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int CNT_W    = 32;
	localparam int FRAME_W  = 9;
	localparam int FIFO_W   = 8;
	localparam int FIFO_D   = 16;
	// ----------------------------------------------------------------
	// Receive states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRDC_IDLE  = 2'b00,
		SRDC_CLEAR = 2'b01,
		SRDC_SHIFT = 2'b10,
		SRDC_DONE  = 2'b11
	} srdc_state_t;
endpackage

// File: common/srdc_fifo_if.sv
// Interface carrying characters from the receiver into its FIFO
`timescale 1ns/10ps
interface srdc_fifo_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// File: hdl/srdc_fifo.sv
// Character FIFO with valid and ready on both sides
`timescale 1ns/10ps
module srdc_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	// Fill side
	srdc_fifo_if.snk          wr,
	// Drain side
	output logic [W-1:0]      rd_data,
	output logic              rd_valid,
	input  wire logic         rd_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_ff [D];
	logic [AW:0]  wptr_ff;
	logic [AW:0]  rptr_ff;
	logic         full;
	logic         push;
	logic         pop;

	assign full     = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
	assign rd_valid = (wptr_ff != rptr_ff);
	assign wr.ready = !full;
	assign push     = wr.valid && !full;
	assign pop      = rd_valid && rd_ready;
	assign rd_data  = mem_ff[rptr_ff[AW-1:0]];

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_ff[wptr_ff[AW-1:0]] <= wr.data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
		end else begin
			if (push) begin
				wptr_ff <= wptr_ff + 1'b1;
			end
			if (pop) begin
				rptr_ff <= rptr_ff + 1'b1;
			end
		end
	end

	no_overflow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		full |=> $stable(wptr_ff) || $past(pop)) else $error("fifo written while full");
endmodule

// File: verification/srdc_modem_model.sv
// Behavioural data set model driving the modem leads of the receiver
`timescale 1ns/10ps
module srdc_modem_model #(
	parameter int BIT_CYC = 256
) (
	// Clock
	input  wire logic ref_clk,
	// From the terminal
	input  wire logic dtr,
	input  wire logic std_out,
	// To the terminal
	output logic      dsr,
	output logic      dcd,
	output logic      ri,
	output logic      rd_in
);
	logic line_bit;
	logic junk;

	initial begin
		dsr = 1'b0;
		dcd = 1'b0;
		ri = 1'b0;
		line_bit = 1'b1;
		junk = 1'b0;
	end

	// ----------------------------------------------------------------
	// Data line
	// ----------------------------------------------------------------
	// Without carrier the line carries noise, so gating faults show up
	always @(posedge ref_clk) begin
		junk <= ~junk;
	end
	assign rd_in = dcd ? line_bit : junk;

	// Data set drops the call once the terminal lets go of DTR
	always @(negedge dtr) begin
		repeat (4) @(posedge ref_clk);
		#1;
		dsr = 1'b0;
		dcd = 1'b0;
	end

	// ----------------------------------------------------------------
	// Tasks used by the bench
	// ----------------------------------------------------------------
	task automatic leads(input logic dsr_v, input logic dcd_v, input logic ri_v);
		@(posedge ref_clk);
		#1;
		dsr = dsr_v;
		dcd = dcd_v;
		ri = ri_v;
	endtask

	// Carrier follows ready well inside the on-hook limit
	task automatic answer(input int dcd_wait);
		leads(1'b1, 1'b0, 1'b0);
		repeat (dcd_wait) @(posedge ref_clk);
		leads(1'b1, 1'b1, 1'b0);
	endtask

	task automatic hold_line(input logic v, input int n);
		@(posedge ref_clk);
		#1;
		line_bit = v;
		repeat (n - 1) @(posedge ref_clk);
	endtask

	// Frame goes out start bit first, stop mark last
	task automatic send_bits(input logic [8:0] w);
		for (int i = 8; i >= 0; i--) begin
			hold_line(w[i], BIT_CYC);
		end
	endtask
endmodule

// File: verification/test_serial_receive_dataset_control.sv
// Self-checking bench for the serial receive data-set control block
`timescale 1ns/10ps
module test_serial_receive_dataset_control;
	localparam int BIT_CYC = 256;
	localparam int HOOK = 1000;
	localparam int CA_W = 20;
	localparam int LIMIT = 80000;
	logic       ref_clk;
	logic       rst_n;
	logic       normal_test_selector;
	logic       printer_ready;
	logic       paper_sufficient;
	logic       auto_on_ready;
	logic       fifo_ready;
	logic       receive_message_out;
	logic       character_available;
	logic       rd_out;
	logic [8:0] char_word;
	logic       dsr;
	logic       dcd;
	logic       ri;
	logic       rd_in;
	logic       dtr;
	logic       std_out;
	logic [7:0] fifo_data;
	logic       fifo_valid;
	logic       on_hook_expired;
	logic       overrun;
	logic       ca_early;
	int         mismatches = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	int         ca_len = 0;
	int         ready_mode = 0;
	logic [7:0] fifo_q[$];
	logic [8:0] ca_q[$];
	logic [8:0] w;
	int unsigned seed_dummy;

	srdc_top #(.PRESCALE(2), .ON_HOOK_LEN(HOOK), .CA_LATE(CA_W), .CA_DLY(CA_W),
		.CA_LEN(CA_W), .LATE_DESIGN(1'b1)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .normal_test_selector(normal_test_selector),
		.printer_ready(printer_ready), .paper_sufficient(paper_sufficient),
		.auto_on_ready(auto_on_ready), .receive_message_out(receive_message_out),
		.character_available(character_available), .rd_out(rd_out), .char_word(char_word),
		.dsr(dsr), .dcd(dcd), .ri(ri), .rd_in(rd_in), .dtr(dtr), .std_out(std_out),
		.fifo_data(fifo_data), .fifo_valid(fifo_valid), .fifo_ready(fifo_ready),
		.on_hook_expired(on_hook_expired), .overrun(overrun));

	// Early-variant copy on the same leads; only its character-available pulse is watched
	srdc_top #(.PRESCALE(2), .ON_HOOK_LEN(HOOK), .CA_LATE(CA_W), .CA_DLY(CA_W),
		.CA_LEN(CA_W), .LATE_DESIGN(1'b0)) dut_early (
		.ref_clk(ref_clk), .rst_n(rst_n), .normal_test_selector(normal_test_selector),
		.printer_ready(printer_ready), .paper_sufficient(paper_sufficient),
		.auto_on_ready(auto_on_ready), .receive_message_out(), .character_available(ca_early),
		.rd_out(), .char_word(), .dsr(dsr), .dcd(dcd), .ri(ri), .rd_in(rd_in), .dtr(),
		.std_out(), .fifo_data(), .fifo_valid(), .fifo_ready(fifo_ready),
		.on_hook_expired(), .overrun());

	srdc_modem_model #(.BIT_CYC(BIT_CYC)) modem (
		.ref_clk(ref_clk), .dtr(dtr), .std_out(std_out),
		.dsr(dsr), .dcd(dcd), .ri(ri), .rd_in(rd_in));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Watchers: drain side and character-available pulse
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		#1;
		fifo_ready = (ready_mode == 2) || (ready_mode == 1 && $urandom_range(3) != 0);
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			$display("unexpected hang at %0t: cycles %h limit %h", $time, cycles, LIMIT);
			stop_test();
		end
		if (fifo_valid === 1'b1 && fifo_ready === 1'b1) begin
			if (fifo_q.size() == 0) check(fifo_data, 32'hffff_ffff);
			else check(fifo_data, fifo_q.pop_front());
		end
		if (character_available === 1'b1) ca_len++;
		if (character_available === 1'b1 && ca_len == 1) begin
			check(ca_early, 1'b0);
			if (ca_q.size() == 0) check(char_word, 32'hffff_ffff);
			else check(char_word, ca_q.pop_front());
		end
		if (character_available !== 1'b1 && ca_len != 0) begin
			check(ca_len, CA_W);
			check(ca_early, 1'b1);
			ca_len = 0;
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		normal_test_selector = 1'b1;
		printer_ready = 1'b0;
		paper_sufficient = 1'b0;
		auto_on_ready = 1'b0;
		fifo_ready = 1'b0;
		seed_dummy = $urandom(32'hbfe3);
		repeat (6) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		wait_cyc(2);
		check({receive_message_out, dtr, character_available, rd_out}, 4'h1);
		$display("test reset done");

		// Printer leads decide DTR and STD before any call
		for (int i = 0; i < 16; i++) begin
			{printer_ready, paper_sufficient, auto_on_ready} = 3'($urandom);
			// Long enough for the data set's reaction to a DTR drop to finish
			wait_cyc(6);
			check(dtr, printer_ready & paper_sufficient);
			check(std_out, auto_on_ready);
			check(receive_message_out, 1'b0);
		end
		$display("test leads done");

		{printer_ready, paper_sufficient, auto_on_ready} = 3'h7;
		modem.answer(50);
		wait_cyc(3);
		check(receive_message_out, 1'b1);
		normal_test_selector = 1'b0;
		wait_cyc(3);
		check(receive_message_out, 1'b0);
		normal_test_selector = 1'b1;
		paper_sufficient = 1'b0;
		wait_cyc(3);
		check(dtr, 1'b1);
		paper_sufficient = 1'b1;
		modem.leads(1'b1, 1'b1, 1'b1);
		fork
			modem.hold_line(1'b0, 40);
			begin
				wait_cyc(20);
				check(rd_out, 1'b1);
			end
		join
		modem.hold_line(1'b1, 2 * BIT_CYC);
		modem.leads(1'b1, 1'b1, 1'b0);
		$display("test call done");

		// Back-to-back characters, boundary data first, drain side stalls
		ready_mode = 1;
		for (int i = 0; i < 4; i++) begin
			w = (i == 0) ? 9'h001 : (i == 1) ? 9'h0ff : {1'b0, 7'($urandom), 1'b1};
			fifo_q.push_back(w[7:0]);
			ca_q.push_back(w);
			modem.send_bits(w);
		end
		modem.hold_line(1'b1, 4 * BIT_CYC);
		check(ca_q.size(), 0);
		check(fifo_q.size(), 0);
		$display("test characters done");

		// Fill until refused, then drain to empty
		ready_mode = 0;
		check(overrun, 1'b0);
		for (int i = 0; i < 17; i++) begin
			w = {1'b0, 7'($urandom), 1'b1};
			if (i < 16) fifo_q.push_back(w[7:0]);
			ca_q.push_back(w);
			modem.send_bits(w);
		end
		modem.hold_line(1'b1, BIT_CYC);
		check(overrun, 1'b1);
		ready_mode = 2;
		wait_cyc(40);
		check(fifo_q.size(), 0);
		check(fifo_valid, 1'b0);
		$display("test fifo done");

		// Carrier loss and on-hook expiry
		modem.leads(1'b1, 1'b0, 1'b0);
		wait_cyc(HOOK - 100);
		check(dtr, 1'b1);
		modem.leads(1'b1, 1'b1, 1'b0);
		wait_cyc(5);
		modem.leads(1'b1, 1'b0, 1'b0);
		wait_cyc(HOOK - 100);
		check(dtr, 1'b1);
		// Expiry stands only until the data set answers the DTR drop by dropping DSR
		wait_cyc(102);
		check(on_hook_expired, 1'b1);
		check(dtr, 1'b0);
		check(rd_out, 1'b1);
		wait_cyc(20);
		check(receive_message_out, 1'b0);
		check(dtr, 1'b1);
		check(on_hook_expired, 1'b0);
		$display("test on-hook done");
		stop_test();
	end
endmodule
